// File: hdl/pump_mode_and_sink_control.sv
`timescale 1ns/1ps
module pump_mode_and_sink_control #(
  parameter int SHORT_CYCLES = pump_sink_pkg::DEBOUNCE_SHORT_CYCLES,
  parameter int LONG_CYCLES = pump_sink_pkg::DEBOUNCE_LONG_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire pump_sink_pkg::reg_req_t regReq,
  output logic [7:0] regRdata,
  input wire pump_sink_pkg::gate_src_t gateSrc,
  input wire logic [pump_sink_pkg::NUM_SINKS-1:0] sinkUndervolt,
  output logic [pump_sink_pkg::NUM_SINKS-1:0] sinkEnable,
  output pump_sink_pkg::level_vec_t sinkLevel,
  output pump_sink_pkg::pump_ctl_t pumpCtl,
  output logic irq
);

  typedef struct packed {
    // software visible registers
    logic [7:0] pumpEnable;
    logic [7:0] hvMode;
    logic [7:0] rgbMode;
    pump_sink_pkg::level_vec_t level;
    logic [7:0] pumpControl;
    logic [7:0] monitorRgb;
    logic [7:0] monitorHv;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [7:0] dimSource;

    // pump sequencing
    pump_sink_pkg::pump_ratio_t autoRatio;
    logic longPending;
    logic [pump_sink_pkg::DEB_W-1:0] debCount;
    logic [pump_sink_pkg::NUM_SINKS-1:0] uvPrev;

    // registered outputs
    logic [7:0] rdata;
    logic [pump_sink_pkg::NUM_SINKS-1:0] enable;
    pump_sink_pkg::pump_ctl_t pump;
    logic irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  // limits stop one short: the switch itself takes an edge
  localparam logic [pump_sink_pkg::DEB_W-1:0] SHORT_LIM =
    pump_sink_pkg::DEB_W'(SHORT_CYCLES - 1);
  localparam logic [pump_sink_pkg::DEB_W-1:0] LONG_LIM =
    pump_sink_pkg::DEB_W'(LONG_CYCLES - 1);

  // one decode table shared by gating and the pump request
  function automatic logic [1:0] gateField(
    input logic [7:0] hv,
    input logic [7:0] rgb,
    input int idx
  );
    logic [1:0] f;
    f = 2'h0;
    unique case (idx)
      pump_sink_pkg::SINK1: begin
        f = hv[1:0];
      end
      pump_sink_pkg::SINK2: begin
        f = hv[3:2];
      end
      pump_sink_pkg::RED: begin
        f = rgb[1:0];
      end
      pump_sink_pkg::GREEN: begin
        f = rgb[3:2];
      end
      pump_sink_pkg::BLUE: begin
        f = rgb[5:4];
      end
      default: begin
        f = rgb[7:6];
      end
    endcase
    return f;
  endfunction : gateField

  function automatic logic [pump_sink_pkg::NUM_SINKS-1:0] monitorVec(
    input logic [7:0] rgbSel,
    input logic [7:0] hvSel
  );
    logic [pump_sink_pkg::NUM_SINKS-1:0] m;
    m = '0;
    m[pump_sink_pkg::SINK1] = hvSel[0];
    m[pump_sink_pkg::SINK2] = hvSel[1];
    m[pump_sink_pkg::RED] = rgbSel[4];
    m[pump_sink_pkg::GREEN] = rgbSel[5];
    m[pump_sink_pkg::BLUE] = rgbSel[6];
    m[pump_sink_pkg::SINK6] = hvSel[7];
    return m;
  endfunction : monitorVec

  // inclusive bounds
  function automatic logic inRange(
    input logic [7:0] a,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    return (a >= lo) && (a <= hi);
  endfunction : inRange

  // combinational helpers, all assigned on every pass
  logic [pump_sink_pkg::NUM_SINKS-1:0] monitored;
  logic [pump_sink_pkg::NUM_SINKS-1:0] selActive;
  logic autoAlgo;
  logic autoEn;
  logic runNext;
  logic uvMonitored;
  logic upSwitch;
  logic [7:0] ratioReadback;
  logic [pump_sink_pkg::DEB_W-1:0] debLimit;

  always_comb begin
    // every field holds unless a branch below moves it
    s_d = s_q;
    monitored = monitorVec(s_q.monitorRgb, s_q.monitorHv);
    for (int i = 0; i < pump_sink_pkg::NUM_SINKS; i++) begin
      selActive[i] = gateField(s_q.hvMode, s_q.rgbMode, i) !=
        pump_sink_pkg::GATE_OFF;
    end
    autoAlgo = !s_q.pumpControl[pump_sink_pkg::POS_ALGO + 1];
    autoEn = s_q.pumpControl[pump_sink_pkg::POS_AUTO_EN];
    runNext = s_q.pumpEnable[pump_sink_pkg::POS_SW_ENABLE] ||
      (autoEn && |(monitored & selActive));
    // only monitored sinks may push the ratio up
    uvMonitored = |(sinkUndervolt & monitored);
    if (s_q.longPending) begin
      debLimit = LONG_LIM;
    end else begin
      debLimit = SHORT_LIM;
    end
    // one-cycle pulse, feeds the sticky status bit
    upSwitch = 1'b0;

    // register writes
    if (regReq.wr) begin
      unique case (regReq.addr)
        pump_sink_pkg::OFS_PUMP_ENABLE: begin
          s_d.pumpEnable = regReq.wdata & pump_sink_pkg::MASK_PUMP_ENABLE;
        end
        pump_sink_pkg::OFS_HV_MODE: begin
          s_d.hvMode = regReq.wdata;
        end
        pump_sink_pkg::OFS_RGB_MODE: begin
          s_d.rgbMode = regReq.wdata;
        end
        // level codes go straight to the sinks, no range limit
        pump_sink_pkg::OFS_SINK1_LEVEL: begin
          s_d.level[pump_sink_pkg::SINK1] = regReq.wdata;
        end
        pump_sink_pkg::OFS_SINK2_LEVEL: begin
          s_d.level[pump_sink_pkg::SINK2] = regReq.wdata;
        end
        pump_sink_pkg::OFS_RED_LEVEL: begin
          s_d.level[pump_sink_pkg::RED] = regReq.wdata;
        end
        pump_sink_pkg::OFS_GREEN_LEVEL: begin
          s_d.level[pump_sink_pkg::GREEN] = regReq.wdata;
        end
        pump_sink_pkg::OFS_BLUE_LEVEL: begin
          s_d.level[pump_sink_pkg::BLUE] = regReq.wdata;
        end
        pump_sink_pkg::OFS_SINK6_LEVEL: begin
          s_d.level[pump_sink_pkg::SINK6] = regReq.wdata;
        end
        // unused bits are dropped so they read back as zero
        pump_sink_pkg::OFS_PUMP_CONTROL: begin
          s_d.pumpControl = regReq.wdata & pump_sink_pkg::MASK_PUMP_CONTROL;
        end
        pump_sink_pkg::OFS_MONITOR_RGB: begin
          s_d.monitorRgb = regReq.wdata & pump_sink_pkg::MASK_MONITOR_RGB;
        end
        pump_sink_pkg::OFS_MONITOR_HV: begin
          s_d.monitorHv = regReq.wdata & pump_sink_pkg::MASK_MONITOR_HV;
        end
        pump_sink_pkg::OFS_IRQ_MASK: begin
          s_d.irqMask = regReq.wdata[1:0] & pump_sink_pkg::MASK_IRQ;
        end
        pump_sink_pkg::OFS_DIM_SOURCE: begin
          s_d.dimSource = {7'h0, regReq.wdata[pump_sink_pkg::POS_EXT_DIM]};
        end
        default: begin
          s_d.dimSource = s_q.dimSource;
        end
      endcase
    end

    // automatic ratio tracking and debounce
    // ratio never steps down while running in auto mode; pump-off or manual mode resets it
    if (!runNext || !autoAlgo) begin
      s_d.autoRatio = pump_sink_pkg::RATIO_1TO1;
      s_d.debCount = '0;
      s_d.longPending = 1'b0;
    end else begin
      // pump just came on: arm the long first interval if asked
      if (!s_q.pump.on) begin
        s_d.longPending = s_q.pumpControl[pump_sink_pkg::POS_LONG_FIRST];
        s_d.debCount = '0;
      end else if (s_q.autoRatio == pump_sink_pkg::RATIO_1TO1 &&
                   uvMonitored) begin
        if (s_q.debCount >= debLimit) begin
          s_d.autoRatio = pump_sink_pkg::RATIO_1TO2;
          s_d.debCount = '0;
          s_d.longPending = 1'b0;
          upSwitch = 1'b1;
        end else begin
          s_d.debCount = s_q.debCount + 1'b1;
        end
      end else begin
        // a dip that recovers before expiry restarts the whole interval
        s_d.debCount = '0;
      end
    end

    // pump outputs
    s_d.pump.on = runNext;
    // clock divider select passes straight through
    s_d.pump.clkHalf = s_q.pumpControl[pump_sink_pkg::POS_CLK_HALF];
    if (!runNext) begin
      s_d.pump.ratioDouble = 1'b0;
    end else if (autoAlgo) begin
      s_d.pump.ratioDouble = s_d.autoRatio == pump_sink_pkg::RATIO_1TO2;
    end else begin
      s_d.pump.ratioDouble = s_q.pumpControl[pump_sink_pkg::POS_RATIO + 1];
    end

    // sink gating
    // a sink gated off keeps its level code untouched
    for (int i = 0; i < pump_sink_pkg::NUM_SINKS; i++) begin
      unique case (gateField(s_q.hvMode, s_q.rgbMode, i))
        pump_sink_pkg::GATE_OFF: begin
          s_d.enable[i] = 1'b0;
        end
        pump_sink_pkg::GATE_ON: begin
          s_d.enable[i] = 1'b1;
        end
        pump_sink_pkg::GATE_PWM: begin
          // dimming source bit picks the external or internal pwm
          s_d.enable[i] = s_q.dimSource[pump_sink_pkg::POS_EXT_DIM] ?
            gateSrc.externalDimmingInput : gateSrc.pwmInternal;
        end
        pump_sink_pkg::GATE_PATTERN: begin
          s_d.enable[i] = gateSrc.patternOut;
        end
      endcase
    end

    // interrupt status: set wins over write-one-to-clear
    // status is sticky: cleared only by writing ones or by srst
    s_d.uvPrev = sinkUndervolt & monitored;
    if (regReq.wr && regReq.addr == pump_sink_pkg::OFS_IRQ_STATUS) begin
      s_d.irqStatus = s_q.irqStatus & ~regReq.wdata[1:0];
    end
    s_d.irqStatus[pump_sink_pkg::IRQ_UPSWITCH] =
      s_d.irqStatus[pump_sink_pkg::IRQ_UPSWITCH] | upSwitch;
    s_d.irqStatus[pump_sink_pkg::IRQ_UNDERVOLT] =
      s_d.irqStatus[pump_sink_pkg::IRQ_UNDERVOLT] |
      (|(sinkUndervolt & monitored & ~s_q.uvPrev));
    s_d.irq = |(s_d.irqStatus & s_d.irqMask);

    // read data, valid in the cycle after the strobe
    // manual mode reads back exactly what was written
    ratioReadback = s_q.pumpControl;
    if (autoAlgo) begin
      ratioReadback[pump_sink_pkg::POS_RATIO +: 2] =
        s_q.pump.ratioDouble ? 2'b10 : 2'b00;
    end
    // unmapped and write-only addresses read as zero
    s_d.rdata = 8'h00;
    if (regReq.rd) begin
      unique case (regReq.addr)
        pump_sink_pkg::OFS_PUMP_ENABLE: begin
          s_d.rdata = s_q.pumpEnable;
        end
        pump_sink_pkg::OFS_HV_MODE: begin
          s_d.rdata = s_q.hvMode;
        end
        pump_sink_pkg::OFS_RGB_MODE: begin
          s_d.rdata = s_q.rgbMode;
        end
        pump_sink_pkg::OFS_SINK6_LEVEL: begin
          s_d.rdata = s_q.level[pump_sink_pkg::SINK6];
        end
        pump_sink_pkg::OFS_PUMP_CONTROL: begin
          s_d.rdata = ratioReadback;
        end
        pump_sink_pkg::OFS_MONITOR_RGB: begin
          s_d.rdata = s_q.monitorRgb;
        end
        pump_sink_pkg::OFS_MONITOR_HV: begin
          s_d.rdata = s_q.monitorHv;
        end
        pump_sink_pkg::OFS_UNDERVOLT_A: begin
          s_d.rdata = {sinkUndervolt[pump_sink_pkg::SINK6],
                       sinkUndervolt[pump_sink_pkg::BLUE],
                       sinkUndervolt[pump_sink_pkg::GREEN],
                       sinkUndervolt[pump_sink_pkg::RED], 4'h0};
        end
        pump_sink_pkg::OFS_UNDERVOLT_B: begin
          s_d.rdata = {6'h00, sinkUndervolt[pump_sink_pkg::SINK2],
                       sinkUndervolt[pump_sink_pkg::SINK1]};
        end
        pump_sink_pkg::OFS_IRQ_STATUS: begin
          s_d.rdata = {6'h00, s_q.irqStatus};
        end
        pump_sink_pkg::OFS_IRQ_MASK: begin
          s_d.rdata = {6'h00, s_q.irqMask};
        end
        pump_sink_pkg::OFS_DIM_SOURCE: begin
          s_d.rdata = s_q.dimSource;
        end
        default: begin
          if (inRange(regReq.addr, pump_sink_pkg::OFS_SINK1_LEVEL,
                      pump_sink_pkg::OFS_BLUE_LEVEL)) begin
            s_d.rdata = s_q.level[3'(regReq.addr -
                                     pump_sink_pkg::OFS_SINK1_LEVEL)];
          end
        end
      endcase
    end

    // reset last so it overrides any write taken in the same cycle
    if (srst) begin
      s_d = '0;
      s_d.pumpEnable = pump_sink_pkg::RST_ZERO;
      s_d.dimSource = pump_sink_pkg::RST_ZERO;
      s_d.pumpControl = pump_sink_pkg::RST_PUMP_CONTROL;
      s_d.monitorRgb = pump_sink_pkg::RST_MONITOR_RGB;
      s_d.monitorHv = pump_sink_pkg::RST_MONITOR_HV;
      s_d.hvMode = pump_sink_pkg::RST_ZERO;
      s_d.rgbMode = pump_sink_pkg::RST_ZERO;
    end
  end

  // single register stage holds the whole state
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // every output is a register bit, nothing combinational leaves
  assign regRdata = s_q.rdata;
  assign sinkEnable = s_q.enable;
  assign sinkLevel = s_q.level;
  assign pumpCtl = s_q.pump;
  assign irq = s_q.irq;

endmodule : pump_mode_and_sink_control

// File: shared/pump_sink_pkg.sv
package pump_sink_pkg;

  localparam int NUM_SINKS = 6;
  // sink index order used throughout
  localparam int SINK1 = 0;
  localparam int SINK2 = 1;
  localparam int RED = 2;
  localparam int GREEN = 3;
  localparam int BLUE = 4;
  localparam int SINK6 = 5;

  localparam logic [7:0] OFS_PUMP_ENABLE = 8'h00;
  localparam logic [7:0] OFS_HV_MODE = 8'h01;
  localparam logic [7:0] OFS_RGB_MODE = 8'h02;
  localparam logic [7:0] OFS_SINK1_LEVEL = 8'h09;
  localparam logic [7:0] OFS_SINK2_LEVEL = 8'h0A;
  localparam logic [7:0] OFS_RED_LEVEL = 8'h0B;
  localparam logic [7:0] OFS_GREEN_LEVEL = 8'h0C;
  localparam logic [7:0] OFS_BLUE_LEVEL = 8'h0D;
  localparam logic [7:0] OFS_PUMP_CONTROL = 8'h23;
  localparam logic [7:0] OFS_MONITOR_RGB = 8'h24;
  localparam logic [7:0] OFS_MONITOR_HV = 8'h25;
  localparam logic [7:0] OFS_UNDERVOLT_A = 8'h2A;
  localparam logic [7:0] OFS_UNDERVOLT_B = 8'h2B;
  localparam logic [7:0] OFS_SINK6_LEVEL = 8'h2F;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h31;
  localparam logic [7:0] OFS_DIM_SOURCE = 8'h32;

  // writable bits of each control register
  localparam logic [7:0] MASK_PUMP_ENABLE = 8'h04;
  localparam logic [7:0] MASK_PUMP_CONTROL = 8'h7F;
  localparam logic [7:0] MASK_MONITOR_RGB = 8'h70;
  localparam logic [7:0] MASK_MONITOR_HV = 8'h83;
  localparam logic [1:0] MASK_IRQ = 2'h3;

  localparam logic [7:0] RST_PUMP_CONTROL = 8'h40;
  localparam logic [7:0] RST_MONITOR_RGB = 8'h70;
  localparam logic [7:0] RST_MONITOR_HV = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions
  localparam int POS_SW_ENABLE = 2;
  localparam int POS_CLK_HALF = 0;
  localparam int POS_RATIO = 1;
  localparam int POS_ALGO = 3;
  localparam int POS_LONG_FIRST = 5;
  localparam int POS_AUTO_EN = 6;
  localparam int POS_EXT_DIM = 0;
  localparam int IRQ_UPSWITCH = 0;
  localparam int IRQ_UNDERVOLT = 1;

  localparam int CLK_MHZ = 200;
  localparam int DEBOUNCE_SHORT_US = 240;
  localparam int DEBOUNCE_LONG_MS = 2;
  localparam int DEBOUNCE_SHORT_CYCLES = DEBOUNCE_SHORT_US * CLK_MHZ;
  localparam int DEBOUNCE_LONG_CYCLES = DEBOUNCE_LONG_MS * 1000 * CLK_MHZ;
  localparam int DEB_W = 19;

  typedef enum logic [1:0] {
    GATE_OFF = 2'b00,
    GATE_ON = 2'b01,
    GATE_PWM = 2'b10,
    GATE_PATTERN = 2'b11
  } gate_sel_t;

  typedef enum logic {
    RATIO_1TO1 = 1'b0,
    RATIO_1TO2 = 1'b1
  } pump_ratio_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic pwmInternal;
    logic externalDimmingInput;
    logic patternOut;
  } gate_src_t;

  typedef struct packed {
    logic on;
    logic ratioDouble;
    logic clkHalf;
  } pump_ctl_t;

  typedef logic [NUM_SINKS-1:0][7:0] level_vec_t;

endpackage : pump_sink_pkg

// File: dv/pump_sink_asserts.sv
`timescale 1ns/1ps
module pump_sink_asserts #(
  parameter int SHORT_CYCLES = 8,
  parameter int LONG_CYCLES = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire pump_sink_pkg::reg_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire pump_sink_pkg::gate_src_t gateSrc,
  input wire logic [pump_sink_pkg::NUM_SINKS-1:0] sinkUndervolt,
  input wire logic [pump_sink_pkg::NUM_SINKS-1:0] sinkEnable,
  input wire pump_sink_pkg::level_vec_t sinkLevel,
  input wire pump_sink_pkg::pump_ctl_t pumpCtl,
  input wire logic irq
);
  // shadows of the pump registers, rebuilt from the bus alone
  logic [7:0] ctl_q;
  logic swEn_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= 8'h40;
      swEn_q <= 1'b0;
    end else if (regReq.wr && regReq.addr == 8'h23) begin
      ctl_q <= regReq.wdata & 8'h7F;
    end else if (regReq.wr && regReq.addr == 8'h00) begin
      swEn_q <= regReq.wdata[2];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_RDATA_IDLE: assert property (
    !$past(regReq.rd) |-> regRdata == 8'h00) else $error("rdata not idle");
  AST_FLAGS_A: assert property (
    regReq.rd && regReq.addr == 8'h2A |=>
    regRdata == {$past(sinkUndervolt[5:2]), 4'h0}) else $error("flags a");
  AST_SINK1_ONOFF: assert property (
    regReq.wr && regReq.addr == 8'h01 && !regReq.wdata[1] |->
    ##2 sinkEnable[0] == $past(regReq.wdata[0], 2)) else $error("sink1 gate");
  AST_SINK6_PATTERN: assert property (
    regReq.wr && regReq.addr == 8'h02 && regReq.wdata[7:6] == 2'b11 |->
    ##2 sinkEnable[5] == $past(gateSrc.patternOut)) else $error("pattern");
  AST_LEVEL_COPY: assert property (
    regReq.wr && regReq.addr == 8'h09 |->
    ##2 sinkLevel[0] == $past(regReq.wdata, 2)) else $error("level copy");
  AST_RATIO_REST: assert property (
    !pumpCtl.on |-> !pumpCtl.ratioDouble) else $error("ratio while off");
  AST_FIRST_DEBOUNCE: assert property (
    $rose(pumpCtl.on) && !ctl_q[4] |-> !pumpCtl.ratioDouble [*8])
    else $error("up-switch too early");
  AST_MANUAL_RATIO: assert property (
    ctl_q[4] && pumpCtl.on && $past(pumpCtl.on) && $stable(ctl_q) |->
    pumpCtl.ratioDouble == ctl_q[2]) else $error("manual ratio");
  AST_SW_ONLY: assert property (
    !ctl_q[6] && $stable(ctl_q) && $stable(swEn_q) |-> pumpCtl.on == swEn_q)
    else $error("pump not following sw enable");
  AST_MASK_QUIET: assert property (
    regReq.wr && regReq.addr == 8'h31 && regReq.wdata[1:0] == 2'b00 |->
    ##2 !irq) else $error("irq while masked");
  COV_UP: cover property ($rose(pumpCtl.ratioDouble));
  COV_IRQ: cover property ($rose(irq));
  COV_ON: cover property ($rose(pumpCtl.on));
endmodule : pump_sink_asserts

bind pump_mode_and_sink_control pump_sink_asserts #(
  .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)
) chk (.clk(clk), .srst(srst), .regReq(regReq), .regRdata(regRdata),
  .gateSrc(gateSrc), .sinkUndervolt(sinkUndervolt), .sinkEnable(sinkEnable),
  .sinkLevel(sinkLevel), .pumpCtl(pumpCtl), .irq(irq));

// File: dv/pump_mode_and_sink_control_bench.sv
`timescale 1ns/1ps
module pump_mode_and_sink_control_bench;
  localparam int SHORT = 8;
  localparam int LONG = 20;
  localparam logic [7:0] RST_ADDR [6] = '{8'h01, 8'h02, 8'h23, 8'h24,
    8'h25, 8'h03};
  localparam logic [7:0] RST_VAL [6] = '{8'h00, 8'h00, 8'h40, 8'h70,
    8'h00, 8'h00};
  localparam logic [7:0] LVL_ADDR [6] = '{8'h09, 8'h0A, 8'h0B, 8'h0C,
    8'h0D, 8'h2F};
  logic clk = 1'b0;
  logic srst = 1'b1;
  pump_sink_pkg::reg_req_t regReq = '0;
  pump_sink_pkg::gate_src_t gateSrc = '0;
  logic [5:0] sinkUndervolt = 6'h00;
  logic [7:0] regRdata;
  logic [5:0] sinkEnable;
  pump_sink_pkg::level_vec_t sinkLevel;
  pump_sink_pkg::pump_ctl_t pumpCtl;
  logic irq;
  int failures = 0;
  int samplesChecked = 0;
  logic [7:0] v;
  logic [7:0] lv [6];
  int n;
  always #2.5 clk = ~clk;
  pump_mode_and_sink_control #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut (
    .clk(clk), .srst(srst), .regReq(regReq), .regRdata(regRdata),
    .gateSrc(gateSrc), .sinkUndervolt(sinkUndervolt), .sinkEnable(sinkEnable),
    .sinkLevel(sinkLevel), .pumpCtl(pumpCtl), .irq(irq));
  task automatic give_verdict();
    if (failures == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq.wr <= 1'b1;
    regReq.addr <= a;
    regReq.wdata <= d;
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge clk);
    regReq.rd <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask : rd
  // outputs trail a register write by one extra edge
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic set_uv(input logic [5:0] u);
    @(posedge clk);
    sinkUndervolt <= u;
  endtask : set_uv
  // window allows for the arm and switch cycles around the count
  task automatic wait_up(input int lim);
    n = 0;
    while (pumpCtl.ratioDouble !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk8({7'h00, n >= lim && n <= lim + 3}, 8'h01);
  endtask : wait_up
  function automatic logic gate_exp(input logic [1:0] m, input logic ext,
    input pump_sink_pkg::gate_src_t g);
    case (m)
      2'b00: return 1'b0;
      2'b01: return 1'b1;
      2'b10: return ext ? g.externalDimmingInput : g.pwmInternal;
      default: return g.patternOut;
    endcase
  endfunction : gate_exp
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h11a2_79f7));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    foreach (RST_ADDR[i]) begin
      rd(RST_ADDR[i]);
      chk8(v, RST_VAL[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rd(LVL_ADDR[i]);
      chk8(v, 8'h00);
      lv[i] = (i == 5) ? 8'hFF : 8'($urandom);
      wr(LVL_ADDR[i], lv[i]);
    end
    settle();
    for (int i = 0; i < 6; i++) begin
      rd(LVL_ADDR[i]);
      chk8(v, lv[i]);
      chk8(sinkLevel[i], lv[i]);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      gateSrc <= 3'($urandom);
      wr(8'h32, {7'h00, k[2]});
      wr(8'h01, {4'h0, k[1:0], k[1:0]});
      wr(8'h02, {4{k[1:0]}});
      settle();
      for (int i = 0; i < 6; i++) begin
        chk8({7'h00, sinkEnable[i]},
          {7'h00, gate_exp(k[1:0], k[2], gateSrc)});
      end
    end
    wr(8'h2A, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      set_uv((k == 0) ? 6'h3F : 6'($urandom));
      rd(8'h2A);
      chk8(v, {sinkUndervolt[5:2], 4'h0});
      rd(8'h2B);
      chk8(v, {6'h00, sinkUndervolt[1:0]});
    end
    set_uv(6'h00);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h23, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h25, 8'h83);
    settle();
    chk8({7'h00, pumpCtl.on}, 8'h00);
    wr(8'h00, 8'h04);
    settle();
    chk8({7'h00, pumpCtl.on}, 8'h01);
    wr(8'h00, 8'h00);
    settle();
    chk8({6'h00, pumpCtl.on, pumpCtl.ratioDouble}, 8'h00);
    wr(8'h25, 8'h00);
    wr(8'h23, 8'h40);
    settle();
    chk8({7'h00, pumpCtl.on}, 8'h00);
    wr(8'h30, 8'h03);
    wr(8'h31, 8'h01);
    wr(8'h25, 8'h01);
    settle();
    chk8({7'h00, pumpCtl.on}, 8'h01);
    set_uv(6'h01);
    wait_up(SHORT);
    rd(8'h23);
    chk8(v, 8'h44);
    chk8({7'h00, irq}, 8'h01);
    wr(8'h30, 8'h03);
    settle();
    chk8({7'h00, irq}, 8'h00);
    set_uv(6'h00);
    wr(8'h01, 8'h00);
    settle();
    chk8({6'h00, pumpCtl.on, pumpCtl.ratioDouble}, 8'h00);
    wr(8'h23, 8'h60);
    wr(8'h01, 8'h01);
    set_uv(6'h01);
    wait_up(LONG);
    set_uv(6'h00);
    for (int c = 3; c >= 0; c--) begin
      wr(8'h23, 8'h70 | 8'(c << 1));
      settle();
      chk8({7'h00, pumpCtl.ratioDouble}, {7'h00, c[1]});
      rd(8'h23);
      chk8(v, 8'h70 | 8'(c << 1));
    end
    wr(8'h23, 8'h69);
    set_uv(6'h01);
    wait_up(SHORT);
    chk8({7'h00, pumpCtl.clkHalf}, 8'h01);
    rd(8'h23);
    chk8(v, 8'h6D);
    wr(8'h31, 8'h00);
    settle();
    give_verdict();
  end
endmodule : pump_mode_and_sink_control_bench
